// ===== verilog/afe_power_reset_adc_ctrl_regs.sv
// Purpose: power, reset, restart, auxiliary control and result registers behind AXI4-Lite
// Assumes: converter result and power-mode acknowledge come from logic on mclk
// Notes: only byte lane 0 of a write is meaningful; every register is 8 bits wide
`timescale 1ns/1ps
module afe_power_reset_adc_ctrl_regs
	import afe_regs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire conv_result_t      convResult,
	input  wire power_mode_t       powerModeInEffect,
	output afe_ctrl_t              afeCtrl,
	output logic                   convRestart,
	output logic                   regReset,
	output logic                   calibCoeffClear,
	output logic                   irq
);

	// decode helpers shared by the read and write paths
	function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
		regIndex = addr[IDX_LSB +: IDX_W];
	endfunction

	function automatic logic inRange(input logic [ADDR_W-1:0] addr);
		inRange = (addr[ADDR_W-1:IDX_LSB+IDX_W] == '0);
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr, input logic forWrite);
		logic [IDX_W-1:0] idx;
		idx = regIndex(addr);
		isMapped = 1'b0;
		if (inRange(addr)) begin
			unique case (idx)
				IDX_RESET_CMD, IDX_RESTART, IDX_IRQ_CLEAR:
					isMapped = forWrite;
				IDX_READY, IDX_RES_HI, IDX_RES_LO, IDX_CH_STATUS, IDX_IRQ_STATUS:
					isMapped = !forWrite;
				IDX_SPI_LOCK, IDX_PWR, IDX_AUX, IDX_IRQ_ENABLE, IDX_RES_RSVD:
					isMapped = 1'b1;
				default:
					isMapped = 1'b0;
			endcase
		end
	endfunction

	// write channel capture
	logic [ADDR_W-1:0] awAddr_ff;
	logic              awHeld_ff;
	logic [7:0]        wByte_ff;
	logic              wLane0_ff;
	logic              wHeld_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              awready_ff;
	logic              wready_ff;

	logic doWrite;
	logic wrMapped;
	logic [IDX_W-1:0] wrIdx;
	logic wrEn;

	assign doWrite  = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign wrMapped = isMapped(awAddr_ff, 1'b1);
	assign wrIdx    = regIndex(awAddr_ff);
	assign wrEn     = doWrite && wrMapped && wLane0_ff;

	// read channel
	logic              arready_ff;
	logic              rvalid_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [1:0]        rresp_ff;
	logic              rdTake;
	logic [IDX_W-1:0]  rdIdx;
	logic              rdMapped;

	assign rdTake   = s_axi_arvalid && arready_ff;
	assign rdIdx    = regIndex(s_axi_araddr);
	assign rdMapped = isMapped(s_axi_araddr, 1'b0);

	// register state
	logic        fullReset;
	logic        spiLock_ff;
	logic        spiEnable_ff;
	power_mode_t pwrReq_ff;
	logic [6:0]  aux_ff;
	logic        newData_ff;
	logic [15:0] result_ff;
	logic [7:0]  lowShadow_ff;
	logic        stale_ff;
	logic [IRQ_W-1:0] irqStatus_ff;
	logic [IRQ_W-1:0] irqEnable_ff;
	logic        restart_ff;
	logic        regReset_ff;
	logic        calClr_ff;
	logic        irq_ff;
	afe_ctrl_t   ctrl_ff;
	logic        resultRead;
	logic        staleEvent;

	assign fullReset  = wrEn && (wrIdx == IDX_RESET_CMD)
			&& (wByte_ff == FULL_RESET_CODE);
	assign resultRead = rdTake && rdMapped
			&& ((rdIdx == IDX_RES_HI) || (rdIdx == IDX_RES_LO));
	assign staleEvent = resultRead && !newData_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_ff  <= 1'b0;
			awAddr_ff  <= '0;
			awready_ff <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_ff) begin
				awHeld_ff  <= 1'b1;
				awAddr_ff  <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				awHeld_ff  <= 1'b0;
				awready_ff <= 1'b1;
			end else if (!awHeld_ff) begin
				awready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wHeld_ff  <= 1'b0;
			wByte_ff  <= '0;
			wLane0_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && wready_ff) begin
				wHeld_ff  <= 1'b1;
				wByte_ff  <= s_axi_wdata[REG_W-1:0];
				wLane0_ff <= s_axi_wstrb[0];
				wready_ff <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				wHeld_ff  <= 1'b0;
				wready_ff <= 1'b1;
			end else if (!wHeld_ff) begin
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (doWrite) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// read data is sampled at acceptance so read side effects happen exactly once
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (ce) begin
			if (rdTake) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rresp_ff   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
				rdata_ff   <= '0;
				if (rdMapped) begin
					unique case (rdIdx)
						IDX_SPI_LOCK:
							rdata_ff[SPI_RST_BIT] <= spiEnable_ff;
						IDX_PWR:
							rdata_ff[1:0] <= powerModeInEffect;
						IDX_AUX:
							rdata_ff[6:0] <= aux_ff;
						IDX_READY:
							rdata_ff[7:0] <= newData_ff ? READY_NEW : READY_NONE;
						IDX_RES_HI:
							rdata_ff[7:0] <= result_ff[15:8];
						IDX_RES_LO:
							rdata_ff[7:0] <= lowShadow_ff;
						IDX_CH_STATUS:
							rdata_ff[STALE_BIT] <= stale_ff;
						IDX_IRQ_STATUS:
							rdata_ff[IRQ_W-1:0] <= irqStatus_ff;
						IDX_IRQ_ENABLE:
							rdata_ff[IRQ_W-1:0] <= irqEnable_ff;
						default:
							rdata_ff <= '0;
					endcase
				end
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end else if (!rvalid_ff) begin
				arready_ff <= 1'b1;
			end
		end
	end

	// serial-port reset enable takes its first write only
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			spiEnable_ff <= 1'b0;
			spiLock_ff   <= 1'b0;
		end else if (ce) begin
			if (fullReset) begin
				spiEnable_ff <= 1'b0;
				spiLock_ff   <= 1'b0;
			end else if (wrEn && (wrIdx == IDX_SPI_LOCK) && !spiLock_ff) begin
				spiEnable_ff <= wByte_ff[SPI_RST_BIT];
				spiLock_ff   <= 1'b1;
			end
		end
	end

	// code 2 is undefined, so such a write leaves the request unchanged
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pwrReq_ff <= PWR_ACTIVE;
		end else if (ce) begin
			if (fullReset) begin
				pwrReq_ff <= PWR_ACTIVE;
			end else if (wrEn && (wrIdx == IDX_PWR)) begin
				unique case (wByte_ff[1:0])
					PWR_ACTIVE:  pwrReq_ff <= PWR_ACTIVE;
					PWR_DOWN:    pwrReq_ff <= PWR_DOWN;
					PWR_STANDBY: pwrReq_ff <= PWR_STANDBY;
					default:     pwrReq_ff <= pwrReq_ff;
				endcase
			end
		end
	end

	// current codes above A are not defined; the old setting is kept
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			aux_ff <= '0;
		end else if (ce) begin
			if (fullReset) begin
				aux_ff <= '0;
			end else if (wrEn && (wrIdx == IDX_AUX)) begin
				aux_ff[6:4] <= wByte_ff[6:4];
				if (wByte_ff[3:0] <= CUR_MAX) begin
					aux_ff[3:0] <= wByte_ff[3:0];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= '{PWR_ACTIVE, 1'b0, 1'b0, CUR_ZERO, 1'b0};
		end else if (ce) begin
			ctrl_ff.powerMode               <= pwrReq_ff;
			ctrl_ff.extClockDetectBypass    <= aux_ff[AUX_BYPASS_BIT];
			ctrl_ff.clockSelectExternal     <= aux_ff[AUX_BYPASS_BIT]
					&& aux_ff[AUX_CLKSEL_BIT];
			ctrl_ff.excitationCurrentSelect <= aux_ff[3:0];
			ctrl_ff.serialResetEnable       <= spiEnable_ff;
		end
	end

	// one-cycle strobes toward the converter
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			restart_ff  <= 1'b0;
			regReset_ff <= 1'b0;
			calClr_ff   <= 1'b0;
		end else if (ce) begin
			restart_ff  <= fullReset || (wrEn && (wrIdx == IDX_RESTART)
					&& wByte_ff[RESTART_BIT]);
			regReset_ff <= fullReset;
			calClr_ff   <= fullReset && aux_ff[AUX_CAL_CLR_BIT];
		end
	end

	// high byte read copies the low byte into its shadow; any later result overwrites the shadow before the low read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			result_ff    <= RESULT_RESET;
			lowShadow_ff <= '0;
			newData_ff   <= 1'b0;
			stale_ff     <= 1'b0;
		end else if (ce) begin
			if (fullReset) begin
				result_ff    <= RESULT_RESET;
				lowShadow_ff <= '0;
				newData_ff   <= 1'b0;
				stale_ff     <= 1'b0;
			end else begin
				if (resultRead) begin
					stale_ff <= !newData_ff;
				end
				if (rdTake && rdMapped && (rdIdx == IDX_RES_HI)) begin
					lowShadow_ff <= result_ff[7:0];
				end
				if (convResult.valid) begin
					result_ff  <= convResult.data;
					newData_ff <= 1'b1;
					if (!(rdTake && rdMapped && (rdIdx == IDX_RES_HI))) begin
						lowShadow_ff <= convResult.data[7:0];
					end
				end else if (rdTake && rdMapped && (rdIdx == IDX_RES_LO)) begin
					newData_ff <= 1'b0;
				end
			end
		end
	end

	// sticky status: a new event wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irqStatus_ff <= '0;
			irqEnable_ff <= '0;
			irq_ff       <= 1'b0;
		end else if (ce) begin
			if (fullReset) begin
				irqStatus_ff <= '0;
				irqEnable_ff <= '0;
			end else begin
				if (wrEn && (wrIdx == IDX_IRQ_ENABLE)) begin
					irqEnable_ff <= wByte_ff[IRQ_W-1:0];
				end
				irqStatus_ff <= (irqStatus_ff
						& ~((wrEn && (wrIdx == IDX_IRQ_CLEAR))
						? wByte_ff[IRQ_W-1:0] : '0))
						| {staleEvent, convResult.valid};
			end
			irq_ff <= |(irqStatus_ff & irqEnable_ff);
		end
	end

	assign s_axi_awready   = awready_ff;
	assign s_axi_wready    = wready_ff;
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_arready   = arready_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rdata     = rdata_ff;
	assign s_axi_rresp     = rresp_ff;
	assign afeCtrl         = ctrl_ff;
	assign convRestart     = restart_ff;
	assign regReset        = regReset_ff;
	assign calibCoeffClear = calClr_ff;
	assign irq             = irq_ff;

endmodule

// ===== shared/afe_regs_pkg.sv
// Purpose: constants and carriers for the converter power, reset and result register bank
// Assumes: register indices are kept as printed; byte address = 4 * index on AXI4-Lite
// Notes: interrupt registers live in the free index space above the calibration area
// Operation
// - writing C3 to reset_command resets all registers and restarts conversion; others ignored
// - serial_port_reset_lock bit 0 enables serial-port reset; default disabled
// - lock register takes only its first write; only a register reset unlocks it
// - power_mode_field write codes: 0 active, 1 power-down, 3 stand-by
// - power mode read returns mode in effect, same code; active after reset
// - writing 1 to restart bit 0 restarts conversion; write-only, upper bits reserved
// - aux bit 6 set makes the full reset also clear calibration coefficients
// - aux bit 5 set bypasses external-clock detection; default detection on
// - aux bit 4 selects external clock, effective only while detection is bypassed
// - excitation_current_select: 0 is zero current, 100 uA steps up to code A
// - result_ready_code reads FF when nothing new, 00 to FE when new data
// - result is 16-bit two's complement; high byte 1A, low byte 1B, 1C reserved
// - stale_result_read_flag set on invalid or repeated result read, cleared on valid
package afe_regs_pkg;

	localparam int          ADDR_W   = 12;
	localparam int          DATA_W   = 32;
	localparam int          IDX_W    = 7;
	localparam int          IDX_LSB  = 2;
	localparam int          REG_W    = 8;

	localparam logic [6:0]  IDX_RESET_CMD  = 7'h00;
	localparam logic [6:0]  IDX_SPI_LOCK   = 7'h02;
	localparam logic [6:0]  IDX_PWR        = 7'h08;
	localparam logic [6:0]  IDX_RESTART    = 7'h0B;
	localparam logic [6:0]  IDX_AUX        = 7'h12;
	localparam logic [6:0]  IDX_READY      = 7'h18;
	localparam logic [6:0]  IDX_RES_HI     = 7'h1A;
	localparam logic [6:0]  IDX_RES_LO     = 7'h1B;
	localparam logic [6:0]  IDX_RES_RSVD   = 7'h1C;
	localparam logic [6:0]  IDX_CH_STATUS  = 7'h1E;
	localparam logic [6:0]  IDX_IRQ_STATUS = 7'h60;
	localparam logic [6:0]  IDX_IRQ_CLEAR  = 7'h61;
	localparam logic [6:0]  IDX_IRQ_ENABLE = 7'h62;

	localparam logic [7:0]  FULL_RESET_CODE = 8'hC3;
	localparam int          SPI_RST_BIT     = 0;
	localparam int          RESTART_BIT     = 0;
	localparam int          STALE_BIT       = 0;
	localparam int          AUX_CAL_CLR_BIT = 6;
	localparam int          AUX_BYPASS_BIT  = 5;
	localparam int          AUX_CLKSEL_BIT  = 4;
	localparam logic [3:0]  CUR_ZERO        = 4'h0;
	localparam logic [3:0]  CUR_MAX         = 4'hA;
	localparam logic [7:0]  READY_NONE      = 8'hFF;
	localparam logic [7:0]  READY_NEW       = 8'h00;
	localparam logic [15:0] RESULT_RESET    = 16'h0000;

	localparam int          CLK_MHZ            = 10;
	localparam int          RESULT_SPACING_US  = 72;
	localparam int          RESULT_SPACING_CYC = RESULT_SPACING_US * CLK_MHZ;

	localparam int          IRQ_W         = 2;
	localparam int          IRQ_CONV_DONE = 0;
	localparam int          IRQ_STALE     = 1;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PWR_ACTIVE  = 2'h0,
		PWR_DOWN    = 2'h1,
		PWR_STANDBY = 2'h3
	} power_mode_t;

	typedef struct packed {
		power_mode_t powerMode;
		logic        extClockDetectBypass;
		logic        clockSelectExternal;
		logic [3:0]  excitationCurrentSelect;
		logic        serialResetEnable;
	} afe_ctrl_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} conv_result_t;

endpackage

// ===== testbench/afe_regs_chk.sv
// Purpose: port-level assertions for the power, reset and result register bank
// Assumes: one mclk domain; ce may freeze state for a few cycles
// Notes: bound to the design top below the module
`timescale 1ns/1ps
module afe_regs_chk
	import afe_regs_pkg::*;
(
	input wire logic              mclk,
	input wire logic              arst_n,
	input wire logic              ce,
	input wire afe_ctrl_t         afeCtrl,
	input wire logic              convRestart,
	input wire logic              regReset,
	input wire logic              calibCoeffClear,
	input wire logic              s_axi_rvalid,
	input wire logic [DATA_W-1:0] s_axi_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	chk_restart_pulse: assert property (ce && convRestart |=> !convRestart)
		else $error("restart strobe longer than one cycle");
	chk_reset_restarts: assert property (regReset |-> convRestart)
		else $error("full reset without conversion restart");
	chk_reset_clears: assert property (regReset |-> ##[0:2] (afeCtrl == '0))
		else $error("controls not cleared by full reset");
	chk_calib_gate: assert property (calibCoeffClear |-> regReset)
		else $error("coefficient clear outside full reset");
	chk_lock_sticky: assert property ($fell(afeCtrl.serialResetEnable)
		|-> regReset || $past(regReset))
		else $error("serial reset enable dropped without reset");
	chk_clock_gate: assert property (afeCtrl.clockSelectExternal
		|-> afeCtrl.extClockDetectBypass)
		else $error("external clock chosen while detection active");
	chk_current_max: assert property (afeCtrl.excitationCurrentSelect <= CUR_MAX)
		else $error("excitation current code above range");
	chk_power_code: assert property (afeCtrl.powerMode != 2'h2)
		else $error("undefined power mode code");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above byte lane not zero");
endmodule

bind afe_power_reset_adc_ctrl_regs afe_regs_chk chk_u (.mclk(mclk), .arst_n(arst_n),
	.ce(ce), .afeCtrl(afeCtrl), .convRestart(convRestart), .regReset(regReset),
	.calibCoeffClear(calibCoeffClear), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata));

// ===== testbench/afe_conv_model.sv
// Purpose: converter-side model feeding results and power-mode status
// Assumes: power mode settles a fixed few cycles after the request
// Notes: result data is scrambled outside its valid pulse
`timescale 1ns/1ps
module afe_conv_model
	import afe_regs_pkg::*;
#(
	parameter int MODE_LAG = 3
)
(
	input  wire logic      mclk,
	input  wire logic      arst_n,
	input  wire afe_ctrl_t afeCtrl,
	output conv_result_t   convResult,
	output power_mode_t    powerModeInEffect
);
	power_mode_t modePipe_ff [MODE_LAG];
	initial convResult = '0;
	assign powerModeInEffect = modePipe_ff[MODE_LAG-1];
	// entering a mode takes time, so the echo trails the request
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			modePipe_ff <= '{default: PWR_ACTIVE};
		end else begin
			modePipe_ff[0] <= afeCtrl.powerMode;
			for (int k = 1; k < MODE_LAG; k++) modePipe_ff[k] <= modePipe_ff[k-1];
		end
	end
	task automatic send(input logic [15:0] d);
		@(posedge mclk);
		convResult <= '{valid: 1'b1, data: d};
		@(posedge mclk);
		convResult <= '{valid: 1'b0, data: ~d};
	endtask
endmodule

// ===== testbench/test_afe_power_reset_adc_ctrl_regs.sv
// Purpose: self-checking bench for the register bank over AXI4-Lite
// Assumes: converter model echoes power mode after a short lag
// Notes: ce and wstrb are each dropped once to show freeze and lane masking
`timescale 1ns/1ps
module test_afe_power_reset_adc_ctrl_regs
	import afe_regs_pkg::*;
;
	logic              mclk = 1'b0, arst_n = 1'b0, ce = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [3:0]        wstrb = 4'hF;
	logic [1:0]        bresp, rresp;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	conv_result_t      convResult;
	power_mode_t       powerModeInEffect;
	afe_ctrl_t         afeCtrl;
	logic              convRestart, regReset, calibCoeffClear, irq;
	int                mismatches = 0, total_checks = 0, restarts = 0, resets = 0, clears = 0;
	int                n0, n1;
	logic [7:0]        pwrCodes [3] = '{8'h01, 8'h00, 8'h03};

	afe_power_reset_adc_ctrl_regs dut_u (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .convResult(convResult),
		.powerModeInEffect(powerModeInEffect), .afeCtrl(afeCtrl),
		.convRestart(convRestart), .regReset(regReset),
		.calibCoeffClear(calibCoeffClear), .irq(irq));
	afe_conv_model conv_u (.mclk(mclk), .arst_n(arst_n), .afeCtrl(afeCtrl),
		.convResult(convResult), .powerModeInEffect(powerModeInEffect));

	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		restarts += convRestart;
		resets += regReset;
		clears += calibCoeffClear;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n = 0;
		@(posedge mclk);
		awaddr <= {3'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid || wvalid) && n < 99);
		do @(posedge mclk); while (!bvalid && ++n < 99);
		bready <= 1'b0;
		// a write that never completes must not pass on a default response
		cmp(32'(n >= 99), 32'h0);
		cmp(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [6:0] idx, input logic [7:0] ed, input logic [1:0] er);
		int n = 0;
		@(posedge mclk);
		araddr <= {3'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (!arready && ++n < 99);
		arvalid <= 1'b0;
		do @(posedge mclk); while (!rvalid && ++n < 99);
		rready <= 1'b0;
		cmp(32'(n >= 99), 32'h0);
		cmp(rdata, {24'h0, ed});
		cmp(32'(rresp), 32'(er));
	endtask
	// irq trails its cause by two cycles, so let two edges pass first
	task automatic cmp_irq(input logic e);
		repeat (2) @(posedge mclk);
		cmp(32'(irq), 32'(e));
	endtask
	task automatic test_end(input string s);
		$display("test %s finished", s);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		tally_and_finish;
	end

	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		rd(IDX_SPI_LOCK, 8'h00, RESP_OKAY);
		rd(IDX_PWR, 8'h00, RESP_OKAY);
		rd(IDX_AUX, 8'h00, RESP_OKAY);
		rd(IDX_READY, READY_NONE, RESP_OKAY);
		rd(IDX_RES_RSVD, 8'h00, RESP_OKAY);
		rd(7'h05, 8'h00, RESP_SLVERR);
		wr(IDX_READY, 8'h12, RESP_SLVERR);
		test_end("reset and map");
		wr(IDX_SPI_LOCK, 8'hFF, RESP_OKAY);
		rd(IDX_SPI_LOCK, 8'h01, RESP_OKAY);
		wr(IDX_SPI_LOCK, 8'h00, RESP_OKAY);
		rd(IDX_SPI_LOCK, 8'h01, RESP_OKAY);
		cmp(32'(afeCtrl.serialResetEnable), 1);
		test_end("lock");
		foreach (pwrCodes[k]) begin
			wr(IDX_PWR, pwrCodes[k], RESP_OKAY);
			repeat (8) @(posedge mclk);
			rd(IDX_PWR, pwrCodes[k], RESP_OKAY);
		end
		wr(IDX_PWR, 8'h02, RESP_OKAY);
		repeat (8) @(posedge mclk);
		rd(IDX_PWR, 8'h03, RESP_OKAY);
		test_end("power");
		wr(IDX_AUX, 8'h7A, RESP_OKAY);
		rd(IDX_AUX, 8'h7A, RESP_OKAY);
		cmp(32'(afeCtrl), 32'h1F5);
		wr(IDX_AUX, 8'h9B, RESP_OKAY);
		rd(IDX_AUX, 8'h1A, RESP_OKAY);
		cmp(32'(afeCtrl.clockSelectExternal), 0);
		// lane 0 masked: the write is answered but changes nothing
		wstrb <= 4'hE;
		wr(IDX_AUX, 8'h05, RESP_OKAY);
		wstrb <= 4'hF;
		rd(IDX_AUX, 8'h1A, RESP_OKAY);
		test_end("aux");
		n0 = restarts;
		wr(IDX_RESTART, 8'hFE, RESP_OKAY);
		wr(IDX_RESTART, 8'h01, RESP_OKAY);
		repeat (3) @(posedge mclk);
		cmp(restarts - n0, 1);
		rd(IDX_RESTART, 8'h00, RESP_SLVERR);
		test_end("restart");
		wr(IDX_IRQ_ENABLE, 8'h01, RESP_OKAY);
		conv_u.send(16'h8001);
		cmp_irq(1'b1);
		rd(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
		wr(IDX_IRQ_ENABLE, 8'h00, RESP_OKAY);
		cmp_irq(1'b0);
		wr(IDX_IRQ_ENABLE, 8'h01, RESP_OKAY);
		cmp_irq(1'b1);
		wr(IDX_IRQ_CLEAR, 8'h01, RESP_OKAY);
		cmp_irq(1'b0);
		test_end("interrupt");
		rd(IDX_READY, READY_NEW, RESP_OKAY);
		rd(IDX_RES_HI, 8'h80, RESP_OKAY);
		rd(IDX_RES_LO, 8'h01, RESP_OKAY);
		rd(IDX_CH_STATUS, 8'h00, RESP_OKAY);
		rd(IDX_READY, READY_NONE, RESP_OKAY);
		repeat (RESULT_SPACING_CYC) @(posedge mclk);
		rd(IDX_RES_HI, 8'h80, RESP_OKAY);
		rd(IDX_CH_STATUS, 8'h01, RESP_OKAY);
		rd(IDX_IRQ_STATUS, 8'h02, RESP_OKAY);
		test_end("result");
		wr(IDX_AUX, 8'h40, RESP_OKAY);
		n0 = resets;
		n1 = clears;
		wr(IDX_RESET_CMD, 8'h3C, RESP_OKAY);
		rd(IDX_AUX, 8'h40, RESP_OKAY);
		wr(IDX_RESET_CMD, FULL_RESET_CODE, RESP_OKAY);
		wr(IDX_RESET_CMD, FULL_RESET_CODE, RESP_OKAY);
		repeat (3) @(posedge mclk);
		cmp(resets - n0, 2);
		cmp(clears - n1, 1);
		rd(IDX_AUX, 8'h00, RESP_OKAY);
		rd(IDX_SPI_LOCK, 8'h00, RESP_OKAY);
		wr(IDX_SPI_LOCK, 8'h01, RESP_OKAY);
		rd(IDX_SPI_LOCK, 8'h01, RESP_OKAY);
		test_end("full reset");
		// a result pulse while frozen is lost, so no new data may show
		@(posedge mclk);
		ce <= 1'b0;
		conv_u.send(16'h1234);
		repeat (2) @(posedge mclk);
		ce <= 1'b1;
		rd(IDX_READY, READY_NONE, RESP_OKAY);
		test_end("freeze");
		tally_and_finish;
	end
endmodule
